// ---- include/ufs_pkg.sv ----
package ufs_pkg;

  localparam int ADDR_W = 32;
  localparam int DATA_W = 16;

  // register byte addresses
  localparam logic [31:0] FIFO_CTRL_ADDR   = 32'h50001008;
  localparam logic [31:0] DMA_MODE_ADDR    = 32'h50001094;
  localparam logic [31:0] FIFO_EN_ADDR     = 32'h50001098;
  localparam logic [31:0] RX_TRIG_ADDR     = 32'h5000109c;
  localparam logic [31:0] TX_TRIG_ADDR     = 32'h500010a0;
  localparam logic [31:0] MODE_CTRL_ADDR   = 32'h500010e0;
  localparam logic [31:0] INT_STATUS_ADDR  = 32'h500010e4;
  localparam logic [31:0] INT_MASK_ADDR    = 32'h500010e8;
  localparam logic [31:0] LEVEL_STAT_ADDR  = 32'h500010ec;

  // control register field positions
  localparam int CTL_EN_BIT     = 0;
  localparam int CTL_RXRST_BIT  = 1;
  localparam int CTL_TXRST_BIT  = 2;
  localparam int CTL_DMA_BIT    = 3;
  localparam int CTL_TXTRIG_LO  = 4;
  localparam int CTL_RXTRIG_LO  = 6;
  localparam int MODE_PT_BIT   = 0;

  // interrupt status bits
  localparam int IRQ_N        = 3;
  localparam int EV_RX_TRIG   = 0;
  localparam int EV_TX_EMPTY  = 1;
  localparam int EV_FIFO_RST  = 2;

  // reset values
  localparam logic [1:0] TRIG_RST = 2'h0;
  localparam logic [IRQ_N-1:0] MASK_RST = 3'h0;

  // trigger codes
  localparam logic [1:0] CODE_0 = 2'h0;
  localparam logic [1:0] CODE_1 = 2'h1;
  localparam logic [1:0] CODE_2 = 2'h2;
  localparam logic [1:0] CODE_3 = 2'h3;

  // settings in effect
  typedef struct packed {
    logic [1:0] rxTrig;
    logic [1:0] txTrig;
    logic       dmaMode;
    logic       fifoEn;
  } ufs_ctrl_s;

  localparam ufs_ctrl_s CTRL_RST = '{rxTrig: 2'h0, txTrig: 2'h0, dmaMode: 1'b0, fifoEn: 1'b0};

endpackage

// ---- src/ufs_thresh.sv ----
`timescale 1ns/1ps
// fill level thresholds decoded from the trigger codes
module ufs_thresh #(
  parameter int DEPTH = 16,
  parameter int LVL_W = 5
) (
  input  wire logic [1:0]       rxCode,
  input  wire logic [1:0]       txCode,
  output logic      [LVL_W-1:0] rxThr,
  output logic      [LVL_W-1:0] txThr
);

  localparam logic [LVL_W-1:0] DEP = LVL_W'(DEPTH);

  // the depth itself must fit the level width, or the thresholds wrap
  if (DEPTH < 8 || DEPTH >= (1 << LVL_W)) begin : g_bad
    $error("ufs_thresh: DEPTH does not fit LVL_W");
  end

  function automatic logic [LVL_W-1:0] rxLvl(input logic [1:0] c);
    case (c)
      ufs_pkg::CODE_0: rxLvl = LVL_W'(1);
      ufs_pkg::CODE_1: rxLvl = DEP >> 2;
      ufs_pkg::CODE_2: rxLvl = DEP >> 1;
      default:         rxLvl = DEP - LVL_W'(2);
    endcase
  endfunction

  function automatic logic [LVL_W-1:0] txLvl(input logic [1:0] c);
    case (c)
      ufs_pkg::CODE_0: txLvl = '0;
      ufs_pkg::CODE_1: txLvl = LVL_W'(2);
      ufs_pkg::CODE_2: txLvl = DEP >> 2;
      default:         txLvl = DEP >> 1;
    endcase
  endfunction

  assign rxThr = rxLvl(rxCode);
  assign txThr = txLvl(txCode);

endmodule

// ---- src/ufs_irq.sv ----
`timescale 1ns/1ps
// sticky event bits, write-one-to-clear, masked onto one level output
module ufs_irq #(
  parameter int N = 3
) (
  input  wire logic         ref_clk,
  input  wire logic         rst,
  input  wire logic [N-1:0] events,
  input  wire logic         clrWr,
  input  wire logic [N-1:0] clrBits,
  input  wire logic         maskWr,
  input  wire logic [N-1:0] maskBits,
  output logic      [N-1:0] status_r,
  output logic      [N-1:0] mask_r,
  output logic              irq_r
);

  logic [N-1:0] status_nxt;
  logic [N-1:0] clrMask;

  // the mask reset value is sized for the shared event count
  if (N != ufs_pkg::IRQ_N) begin : g_bad
    $error("ufs_irq: N must match the event count");
  end

  // set wins over a clear in the same cycle
  assign clrMask    = clrWr ? clrBits : '0;
  assign status_nxt = (status_r & ~clrMask) | events;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      status_r <= '0;
      mask_r   <= ufs_pkg::MASK_RST;
      irq_r    <= 1'b0;
    end else begin
      status_r <= status_nxt;
      if (maskWr) begin
        mask_r <= maskBits;
      end
      irq_r <= |(status_nxt & (maskWr ? maskBits : mask_r));
    end
  end

endmodule

// ---- src/ufs_fifo_shadow.sv ----
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ps
// fifo control settings with shadow access, trigger and dma request logic
module ufs_fifo_shadow #(
  parameter int DEPTH = 16,
  parameter int LVL_W = $clog2(DEPTH) + 1
) (
  input  wire logic                        ref_clk,
  input  wire logic                        rst,
  input  wire logic [ufs_pkg::ADDR_W-1:0]  addr,
  input  wire logic [ufs_pkg::DATA_W-1:0]  wrData,
  input  wire logic                        wrStb,
  input  wire logic                        rdStb,
  output logic      [ufs_pkg::DATA_W-1:0]  rdData,
  input  wire logic [LVL_W-1:0]            rxLevel,
  input  wire logic [LVL_W-1:0]            txLevel,
  output logic                             fifoEnable,
  output logic                             rxFifoRst,
  output logic                             txFifoRst,
  output logic                             dmaMode,
  output logic                             rxDataAvail,
  output logic                             txHoldingEmpty,
  output logic                             rxDmaReq_n,
  output logic                             irq
);

  // depth must be a power of two, at least 8, and the level width must leave room for the full level itself
  if (DEPTH < 8 || (DEPTH & (DEPTH - 1)) != 0 || LVL_W != $clog2(DEPTH) + 1) begin : g_bad
    $error("ufs_fifo_shadow: unsupported DEPTH or LVL_W");
  end

  typedef ufs_pkg::ufs_ctrl_s ufs_ctrl_t;

  // address decode
  wire selCtl   = addr == ufs_pkg::FIFO_CTRL_ADDR;
  wire selDma   = addr == ufs_pkg::DMA_MODE_ADDR;
  wire selEn    = addr == ufs_pkg::FIFO_EN_ADDR;
  wire selRx    = addr == ufs_pkg::RX_TRIG_ADDR;
  wire selTx    = addr == ufs_pkg::TX_TRIG_ADDR;
  wire selMode  = addr == ufs_pkg::MODE_CTRL_ADDR;
  wire selStat  = addr == ufs_pkg::INT_STATUS_ADDR;
  wire selMask  = addr == ufs_pkg::INT_MASK_ADDR;
  wire selLevel = addr == ufs_pkg::LEVEL_STAT_ADDR;

  wire wrCtl  = wrStb & selCtl;
  wire wrDma  = wrStb & selDma;
  wire wrEn   = wrStb & selEn;
  wire wrRx   = wrStb & selRx;
  wire wrTx   = wrStb & selTx;
  wire wrMode = wrStb & selMode;

  ufs_ctrl_t ctrl_r;
  ufs_ctrl_t ctrl_nxt;
  logic      ptMode_r;

  // one store serves both the main register and the shadows,
  // so whichever path wrote last is what reads back
  always_comb begin
    ctrl_nxt = ctrl_r;
    if (wrCtl) begin
      ctrl_nxt.fifoEn  = wrData[ufs_pkg::CTL_EN_BIT];
      ctrl_nxt.dmaMode = wrData[ufs_pkg::CTL_DMA_BIT];
      ctrl_nxt.txTrig  = wrData[ufs_pkg::CTL_TXTRIG_LO +: 2];
      ctrl_nxt.rxTrig  = wrData[ufs_pkg::CTL_RXTRIG_LO +: 2];
    end
    if (wrEn) begin
      ctrl_nxt.fifoEn = wrData[0];
    end
    if (wrDma) begin
      ctrl_nxt.dmaMode = wrData[0];
    end
    if (wrRx) begin
      ctrl_nxt.rxTrig = wrData[1:0];
    end
    if (wrTx) begin
      ctrl_nxt.txTrig = wrData[1:0];
    end
  end

  // enable falling edge, from any write path
  wire enFall = ctrl_r.fifoEn & ~ctrl_nxt.fifoEn;
  wire rxRstReq = enFall | (wrCtl & wrData[ufs_pkg::CTL_RXRST_BIT]);
  wire txRstReq = enFall | (wrCtl & wrData[ufs_pkg::CTL_TXRST_BIT]);

  // thresholds
  logic [LVL_W-1:0] rxThr;
  logic [LVL_W-1:0] txThr;

  ufs_thresh #(
    .DEPTH (DEPTH),
    .LVL_W (LVL_W)
  ) u_thresh (
    .rxCode (ctrl_r.rxTrig),
    .txCode (ctrl_r.txTrig),
    .rxThr  (rxThr),
    .txThr  (txThr)
  );

  // trigger hits count only while the fifos are on; the any-data flag rxAny ignores the enable
  wire rxHit  = ctrl_r.fifoEn & (rxLevel >= rxThr);
  wire txHit  = ctrl_r.fifoEn & ptMode_r & (txLevel <= txThr);
  wire rxAny  = rxLevel != '0;

  // dma request: mode 0 asks for any data, mode 1 waits for the trigger
  // and holds until the fifo drains, so bursts are not cut short
  logic rxDmaAct_r;
  logic rxDmaAct_nxt;
  always_comb begin
    if (!ctrl_r.dmaMode) begin
      rxDmaAct_nxt = rxAny;
    end else if (rxHit) begin
      rxDmaAct_nxt = 1'b1;
    end else if (!rxAny) begin
      rxDmaAct_nxt = 1'b0;
    end else begin
      rxDmaAct_nxt = rxDmaAct_r;
    end
  end

  logic rxHit_r;
  logic txHit_r;
  logic rxRst_r;
  logic txRst_r;

  // state and strobes
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ctrl_r     <= ufs_pkg::CTRL_RST;
      ptMode_r   <= 1'b0;
      rxDmaAct_r <= 1'b0;
      rxHit_r    <= 1'b0;
      txHit_r    <= 1'b0;
      rxRst_r    <= 1'b0;
      txRst_r    <= 1'b0;
    end else begin
      ctrl_r     <= ctrl_nxt;
      if (wrMode) begin
        ptMode_r <= wrData[ufs_pkg::MODE_PT_BIT];
      end
      rxDmaAct_r <= rxDmaAct_nxt;
      rxHit_r    <= rxHit;
      txHit_r    <= txHit;
      rxRst_r    <= rxRstReq;
      txRst_r    <= txRstReq;
    end
  end

  // rx and tx events are the rising edges of the conditions; the fifo reset event is the reset request itself
  wire [ufs_pkg::IRQ_N-1:0] events;
  assign events[ufs_pkg::EV_RX_TRIG]  = rxHit & ~rxHit_r;
  assign events[ufs_pkg::EV_TX_EMPTY] = txHit & ~txHit_r;
  assign events[ufs_pkg::EV_FIFO_RST] = rxRstReq | txRstReq;

  logic [ufs_pkg::IRQ_N-1:0] status;
  logic [ufs_pkg::IRQ_N-1:0] mask;

  ufs_irq #(
    .N (ufs_pkg::IRQ_N)
  ) u_irq (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .events   (events),
    .clrWr    (wrStb & selStat),
    .clrBits  (wrData[ufs_pkg::IRQ_N-1:0]),
    .maskWr   (wrStb & selMask),
    .maskBits (wrData[ufs_pkg::IRQ_N-1:0]),
    .status_r (status),
    .mask_r   (mask),
    .irq_r    (irq)
  );

  // read mux; the main control register is write-only and reads zero
  logic [ufs_pkg::DATA_W-1:0] rdMux;
  always_comb begin
    rdMux = '0;
    if (selDma) begin
      rdMux[0] = ctrl_r.dmaMode;
    end else if (selEn) begin
      rdMux[0] = ctrl_r.fifoEn;
    end else if (selRx) begin
      rdMux[1:0] = ctrl_r.rxTrig;
    end else if (selTx) begin
      rdMux[1:0] = ctrl_r.txTrig;
    end else if (selMode) begin
      rdMux[ufs_pkg::MODE_PT_BIT] = ptMode_r;
    end else if (selStat) begin
      rdMux[ufs_pkg::IRQ_N-1:0] = status;
    end else if (selMask) begin
      rdMux[ufs_pkg::IRQ_N-1:0] = mask;
    end else if (selLevel) begin
      rdMux[0] = rxHit_r;
      rdMux[1] = txHit_r;
      rdMux[2] = ~rxDmaAct_r;
    end
  end

  // output flops; read data stands only in the cycle after the strobe
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rdData         <= '0;
      fifoEnable     <= 1'b0;
      rxFifoRst      <= 1'b0;
      txFifoRst      <= 1'b0;
      dmaMode        <= 1'b0;
      rxDataAvail    <= 1'b0;
      txHoldingEmpty <= 1'b0;
      rxDmaReq_n     <= 1'b1;
    end else begin
      rdData         <= rdStb ? rdMux : '0;
      fifoEnable     <= ctrl_r.fifoEn;
      rxFifoRst      <= rxRst_r;
      txFifoRst      <= txRst_r;
      dmaMode        <= ctrl_r.dmaMode;
      rxDataAvail    <= rxHit_r;
      txHoldingEmpty <= txHit_r;
      rxDmaReq_n     <= ~rxDmaAct_r;
    end
  end

endmodule

// ---- test/ufs_fifo_shadow_sva.sv ----
`timescale 1ns/1ps
// output timing against strobes and fill levels
module ufs_fifo_shadow_chk #(
  parameter int DEPTH = 16,
  parameter int LVL_W = 5
) (
  input wire logic             ref_clk,
  input wire logic             rst,
  input wire logic             wrStb,
  input wire logic             rdStb,
  input wire logic [15:0]      rdData,
  input wire logic [LVL_W-1:0] rxLevel,
  input wire logic [LVL_W-1:0] txLevel,
  input wire logic             fifoEnable,
  input wire logic             rxFifoRst,
  input wire logic             txFifoRst,
  input wire logic             rxDataAvail,
  input wire logic             txHoldingEmpty,
  input wire logic             rxDmaReq_n
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // both controller resets lie within two cycles of the enable falling
  a_fall_resets: assert property ($fell(fifoEnable) |-> (rxFifoRst && txFifoRst)
    or ##[1:2] (rxFifoRst && txFifoRst) or ($past(rxFifoRst) && $past(txFifoRst))
    or ($past(rxFifoRst, 2) && $past(txFifoRst, 2))) else $error("no fifo reset");
  a_rxrst_cause: assert property (rxFifoRst |-> $past(wrStb, 2))
    else $error("rx reset without write");
  a_txrst_cause: assert property (txFifoRst |-> $past(wrStb, 2))
    else $error("tx reset without write");
  // highest threshold is two below full, so any code must fire there
  a_rx_full_hit: assert property (fifoEnable && $past(fifoEnable) && $past(fifoEnable, 2)
    && $past(fifoEnable, 3) && $past(rxLevel, 2) >= DEPTH - 2 |-> rxDataAvail)
    else $error("rx hit missing");
  a_rx_avail_cause: assert property (rxDataAvail |-> $past(rxLevel, 2) != 0)
    else $error("rx hit while empty");
  a_tx_hit_level: assert property (txHoldingEmpty |-> $past(txLevel, 2) <= DEPTH / 2)
    else $error("tx hit above half");
  a_dma_req_cause: assert property (!rxDmaReq_n |-> $past(rxLevel, 2) != 0)
    else $error("dma request while empty");
  a_read_idle: assert property (!$past(rdStb) |-> rdData == 16'h0)
    else $error("read data outside read");
  a_en_cause: assert property ($rose(fifoEnable) |-> $past(wrStb) || $past(wrStb, 2)
    || $past(wrStb, 3)) else $error("enable rose without write");
endmodule
bind ufs_fifo_shadow ufs_fifo_shadow_chk #(.DEPTH(DEPTH), .LVL_W(LVL_W)) i_chk (.ref_clk, .rst,
  .wrStb, .rdStb, .rdData, .rxLevel, .txLevel, .fifoEnable, .rxFifoRst, .txFifoRst,
  .rxDataAvail, .txHoldingEmpty, .rxDmaReq_n);

// ---- test/ufs_fifo_shadow_test.sv ----
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin miscompares++; \
  $display("Error %s expected %0h seen %0h", nm, e, g); end end
module ufs_fifo_shadow_test;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic        wrStb = 1'b0;
  logic        rdStb = 1'b0;
  logic [31:0] addr = 32'h0;
  logic [15:0] wrData = 16'h0;
  logic [15:0] rdData;
  logic [15:0] rdVal;
  logic [4:0]  rxLevel = 5'h0;
  logic [4:0]  txLevel = 5'h0;
  logic        fifoEnable, rxFifoRst, txFifoRst, dmaMode, rxDataAvail, txHoldingEmpty;
  logic        rxDmaReq_n, irq;
  int          miscompares = 0;
  int          checked = 0;
  int          seen, k, v;
  int          mSet[4];
  int          rxT[4] = '{1, 4, 8, 14};
  int          txT[4] = '{0, 2, 4, 8};
  logic [31:0] shAddr[4] = '{ufs_pkg::FIFO_EN_ADDR, ufs_pkg::DMA_MODE_ADDR,
                             ufs_pkg::TX_TRIG_ADDR, ufs_pkg::RX_TRIG_ADDR};

  ufs_fifo_shadow i_ufs_fifo_shadow (.ref_clk, .rst, .addr, .wrData, .wrStb, .rdStb, .rdData,
    .rxLevel, .txLevel, .fifoEnable, .rxFifoRst, .txFifoRst, .dmaMode, .rxDataAvail,
    .txHoldingEmpty, .rxDmaReq_n, .irq);

  // free running bus clock
  always #20 ref_clk = ~ref_clk;

  // one-cycle bus strobes, driven just after the edge
  task automatic wr(input logic [31:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    addr <= a;
    wrData <= d;
    wrStb <= 1'b1;
    @(posedge ref_clk);
    wrStb <= 1'b0;
  endtask
  task automatic rd(input logic [31:0] a);
    @(posedge ref_clk);
    addr <= a;
    rdStb <= 1'b1;
    @(posedge ref_clk);
    rdStb <= 1'b0;
    #1 rdVal = rdData;
  endtask
  // levels need two edges to reach outputs, and only one to reach status and irq
  task automatic lv(input int r, input int t);
    @(posedge ref_clk);
    rxLevel <= r[4:0];
    txLevel <= t[4:0];
    repeat (4) @(posedge ref_clk);
    #1;
  endtask
  task automatic print_verdict;
    if (miscompares == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // hang guard, far beyond the expected run length
  initial begin
    repeat (6000) @(posedge ref_clk);
    miscompares++;
    print_verdict();
  end

  initial begin
    k = $urandom(8571);
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    foreach (shAddr[i]) begin
      rd(shAddr[i]);
      `CHK("shadow reset", 0, rdVal)
    end
    rd(32'h500010a4);
    `CHK("unmapped", 0, rdVal)
    // random full writes then one shadow field, all shadows read back
    for (int n = 0; n < 20; n++) begin
      v = $urandom;
      wr(ufs_pkg::FIFO_CTRL_ADDR, v[15:0]);
      mSet = '{v[0], v[3], v[5:4], v[7:6]};
      k = $urandom % 4;
      v = $urandom % 4;
      wr(shAddr[k], v[15:0]);
      mSet[k] = (k < 2) ? v % 2 : v;
      foreach (shAddr[i]) begin
        rd(shAddr[i]);
        `CHK("shadow", mSet[i], rdVal)
      end
      rd(ufs_pkg::FIFO_CTRL_ADDR);
      `CHK("control read", 0, rdVal)
      lv(0, 0);
      `CHK("fifoEnable", mSet[0], fifoEnable)
      `CHK("dmaMode", mSet[1], dmaMode)
    end
    // clearing the enable pulses both controller resets together
    wr(ufs_pkg::FIFO_EN_ADDR, 16'h1);
    lv(0, 0);
    wr(ufs_pkg::FIFO_CTRL_ADDR, 16'h0);
    seen = 0;
    repeat (4) begin
      @(posedge ref_clk);
      #1 seen += (rxFifoRst === 1'b1 && txFifoRst === 1'b1);
    end
    `CHK("fifo reset", 1, seen)
    // rx trigger per code, raising, masking and clearing the interrupt
    wr(ufs_pkg::FIFO_EN_ADDR, 16'h1);
    wr(ufs_pkg::INT_STATUS_ADDR, 16'h7);
    wr(ufs_pkg::INT_MASK_ADDR, 16'h1);
    for (int c = 0; c < 4; c++) begin
      wr(ufs_pkg::RX_TRIG_ADDR, c[15:0]);
      lv(rxT[c] - 1, 16);
      `CHK("rx below", 0, rxDataAvail)
      lv(rxT[c], 16);
      `CHK("rx at", 1, rxDataAvail)
      `CHK("irq", 1, irq)
      wr(ufs_pkg::INT_MASK_ADDR, 16'h0);
      lv(0, 16);
      `CHK("irq masked", 0, irq)
      wr(ufs_pkg::INT_MASK_ADDR, 16'h1);
      wr(ufs_pkg::INT_STATUS_ADDR, 16'h7);
      lv(0, 16);
      `CHK("irq cleared", 0, irq)
    end
    // random levels against the half-full code
    wr(ufs_pkg::RX_TRIG_ADDR, 16'h2);
    for (int n = 0; n < 10; n++) begin
      k = $urandom % 17;
      lv(k, 16 - k);
      `CHK("rx random", int'(k >= rxT[2]), rxDataAvail)
      `CHK("tx mode off", 0, txHoldingEmpty)
      `CHK("dma mode0", int'(k == 0), rxDmaReq_n)
    end
    // tx thresholds exist only in threshold mode
    wr(ufs_pkg::MODE_CTRL_ADDR, 16'h1);
    for (int c = 0; c < 4; c++) begin
      wr(ufs_pkg::TX_TRIG_ADDR, c[15:0]);
      lv(0, txT[c]);
      `CHK("tx at", 1, txHoldingEmpty)
      lv(0, txT[c] + 1);
      `CHK("tx above", 0, txHoldingEmpty)
    end
    wr(ufs_pkg::MODE_CTRL_ADDR, 16'h0);
    lv(0, 0);
    `CHK("tx mode off", 0, txHoldingEmpty)
    // dma mode 1 asserts at trigger and holds until empty
    wr(ufs_pkg::DMA_MODE_ADDR, 16'h1);
    lv(7, 0);
    `CHK("dma below", 1, rxDmaReq_n)
    lv(8, 0);
    `CHK("dma at", 0, rxDmaReq_n)
    lv(3, 0);
    `CHK("dma held", 0, rxDmaReq_n)
    lv(0, 0);
    `CHK("dma empty", 1, rxDmaReq_n)
    print_verdict();
  end
endmodule
